// [hw/pho_pkg.sv]
// Package: register map, field layout, reset values and states for holdover
package pho_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;
  localparam int          IDX_W  = 10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LOCK_CFG = 10'h018;
  localparam logic [IDX_W-1:0] IDX_PIN_MON  = 10'h01A;
  localparam logic [IDX_W-1:0] IDX_REF_SEL  = 10'h01C;
  localparam logic [IDX_W-1:0] IDX_HOLD_CTL = 10'h01D;
  localparam logic [IDX_W-1:0] IDX_DIV0_CTL = 10'h191;
  localparam logic [IDX_W-1:0] IDX_DIV1_CTL = 10'h194;
  localparam logic [IDX_W-1:0] IDX_DIV2_CTL = 10'h197;
  localparam logic [IDX_W-1:0] IDX_DIV3_CTL = 10'h19A;
  localparam logic [IDX_W-1:0] IDX_CLK_ROLE = 10'h1F0;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 10'h1F1;

  // ----------------------------------------------------------------------
  // Storage slots
  // ----------------------------------------------------------------------
  localparam int         NUM_CFG   = 9;
  localparam int         NUM_DIV   = 4;
  localparam logic [3:0] SLOT_LOCK = 4'h0;
  localparam logic [3:0] SLOT_PIN  = 4'h1;
  localparam logic [3:0] SLOT_REF  = 4'h2;
  localparam logic [3:0] SLOT_HOLD = 4'h3;
  localparam logic [3:0] SLOT_DIV0 = 4'h4;
  localparam logic [3:0] SLOT_ROLE = 4'h8;
  localparam logic [3:0] SLOT_STAT = 4'h9;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  localparam logic [7:0] ROLE_MASK = 8'h03;
  localparam logic [7:0] CFG_RST [NUM_CFG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LDC_CNT_LSB = 5;
  localparam int LDC_WIN_BIT = 4;
  localparam int LDC_DIS_BIT = 3;
  localparam int PIN_EXT_BIT = 6;
  localparam int PIN_MODE_MSB = 5;
  localparam int REF_AUTO_BIT = 4;
  localparam int REF_PREF_BIT = 3;
  localparam int REF_BUF_LSB = 1;
  localparam int HOC_CMP_BIT = 3;
  localparam int HOC_EXT_BIT = 1;
  localparam int HOC_EN_BIT  = 0;
  localparam int DIV_IGN_BIT = 6;
  localparam logic [5:0] PIN_MODE_CUR_SRC = 6'h04;

  // ----------------------------------------------------------------------
  // Lock detect cycle counts per counter code
  // ----------------------------------------------------------------------
  localparam logic [7:0] LOCK_CNT_00 = 8'h05;
  localparam logic [7:0] LOCK_CNT_01 = 8'h10;
  localparam logic [7:0] LOCK_CNT_10 = 8'h40;
  localparam logic [7:0] LOCK_CNT_11 = 8'hFF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN  = 3'h1,
    ST_MAN  = 3'h2,
    ST_AUTO = 3'h4
  } pho_state_t;

  typedef enum logic [1:0] {
    ROLE_INT_VCO  = 2'h0,
    ROLE_DIST     = 2'h1,
    ROLE_EXT_OSC  = 2'h2,
    ROLE_ZD_FDBK  = 2'h3
  } pho_role_t;

endpackage : pho_pkg

// [hw/pho_lock_det.sv]
// Digital lock detect: consecutive in-window count, single-cycle unlock
`timescale 1ns/1ps
`default_nettype none
module pho_lock_det
  import pho_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable,
  input  wire logic [1:0] i_count_sel,
  input  wire logic       i_phase_detector_cycle,
  input  wire logic       i_in_window,
  input  wire logic       i_over_unlock,
  output logic            o_lock
);

  // ----------------------------------------------------------------------
  // Count target
  // ----------------------------------------------------------------------
  function automatic logic [7:0] cnt_target(input logic [1:0] sel);
    case (sel)
      2'h0:    cnt_target = LOCK_CNT_00;
      2'h1:    cnt_target = LOCK_CNT_01;
      2'h2:    cnt_target = LOCK_CNT_10;
      default: cnt_target = LOCK_CNT_11;
    endcase
  endfunction

  logic [7:0] cnt_r;
  logic       lock_r;
  wire  [7:0] cnt_inc = cnt_r + 8'h01;
  wire        reach   = cnt_inc >= cnt_target(i_count_sel);

  // ----------------------------------------------------------------------
  // Counter and lock flag
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 8'h00;
      lock_r <= 1'b0;
    end else if (!i_enable) begin
      cnt_r  <= 8'h00;
      lock_r <= 1'b0;
    end else if (i_phase_detector_cycle) begin
      if (lock_r) begin
        // One wide cycle drops lock; hysteresis avoids chatter
        if (i_over_unlock) begin
          lock_r <= 1'b0;
          cnt_r  <= 8'h00;
        end
      end else if (i_in_window) begin
        cnt_r  <= reach ? 8'h00 : cnt_inc;
        lock_r <= reach;
      end else begin
        cnt_r <= 8'h00;
      end
    end
  end

  assign o_lock = lock_r;

endmodule // pho_lock_det
`default_nettype wire

// [hw/pho_holdover.sv]
// Holdover controller: charge pump holdover, lock detect, config registers
//
// Functional notes
// - Holdover enable bit gates both holdover paths
// - Alignment pin falling edge: pump high-Z immediately
// - Release only at next reference detector edge
// - Release pulses feedback B counter reset
// - Bit 6 per divider ignores alignment pin
// - Alignment pin low stops non-ignoring dividers
// - Auto holdover on lock indicator low
// - Comparator off: lock indicator seen high
// - Auto holdover holds while reference absent
// - Re-arm only after lock indicator high
// - Follows selected reference, brief switchover holdover
// - Two-bit counter field; code 00 five cycles
// - Disable bit zero enables digital lock detect
// - Pin code 000100 selects current-source mode
// - External bit selects manual or automatic mode
// - Window bit zero selects high range
// - Reference control: auto switch, preference, buffers
// - Three frequency monitors, oscillator follows clock input
// - One bit selects extended reference threshold
// - Clock input role: distribution, oscillator, zero-delay
// - Lock held until one cycle exceeds unlock
`timescale 1ns/1ps
`default_nettype none
module pho_holdover
  import pho_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [DATA_W-1:0] i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [DATA_W-1:0]      o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic              i_align_n,
  input  wire logic              i_lock_indicator_cmp,
  input  wire logic              i_phase_detector_ref_edge,
  input  wire logic              i_phase_detector_cycle,
  input  wire logic              i_phase_detector_in_window,
  input  wire logic              i_phase_detector_over_unlock,
  input  wire logic              i_first_ref_low,
  input  wire logic              i_second_ref_low,
  input  wire logic              i_vco_low,
  input  wire logic              i_clk_in_low,
  output logic                   o_charge_pump_hiz,
  output logic                   o_bcnt_reset,
  output logic [NUM_DIV-1:0]     o_div_stop,
  output logic                   o_digital_lock_detect,
  output logic                   o_digital_lock_detect_en,
  output logic                   o_lock_window_high,
  output logic [1:0]             o_lock_count_sel,
  output logic [5:0]             o_lock_pin_ctrl,
  output logic                   o_current_source_lock_detect,
  output logic                   o_mon_ext_thresh,
  output logic                   o_ref_auto_switch,
  output logic                   o_ref_prefer_second,
  output logic [1:0]             o_ref_buf_en,
  output logic [1:0]             o_clk_in_role,
  output logic                   o_pll_on
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    case (idx)
      IDX_LOCK_CFG: slot_of = SLOT_LOCK;
      IDX_PIN_MON:  slot_of = SLOT_PIN;
      IDX_REF_SEL:  slot_of = SLOT_REF;
      IDX_HOLD_CTL: slot_of = SLOT_HOLD;
      IDX_DIV0_CTL: slot_of = 4'h4;
      IDX_DIV1_CTL: slot_of = 4'h5;
      IDX_DIV2_CTL: slot_of = 4'h6;
      IDX_DIV3_CTL: slot_of = 4'h7;
      IDX_CLK_ROLE: slot_of = SLOT_ROLE;
      IDX_STATUS:   slot_of = SLOT_STAT;
      default:      slot_of = SLOT_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------------
  logic              aw_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic              w_hold_r;
  logic [7:0]        wdata_r;
  logic              wstrb0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0]        cfg_r [NUM_CFG];

  wire       aw_take  = i_s_axi_awvalid & o_s_axi_awready;
  wire       w_take   = i_s_axi_wvalid & o_s_axi_wready;
  wire       ar_take  = i_s_axi_arvalid & o_s_axi_arready;
  wire       do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [3:0] wr_slot  = slot_of(awaddr_r);
  wire [3:0] rd_slot  = slot_of(i_s_axi_araddr);
  wire       wr_ok    = wr_slot < SLOT_STAT;
  wire       rd_ok    = wr_slot != SLOT_NONE;
  wire       rd_map   = rd_slot != SLOT_NONE;
  wire [7:0] status;
  wire [7:0] rd_byte  = (rd_slot == SLOT_STAT) ? status :
                        (rd_slot < SLOT_STAT) ? cfg_r[rd_slot] : 8'h00;

  assign o_s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign o_s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign o_s_axi_arready = ~rvalid_r;
  assign o_s_axi_bvalid  = bvalid_r;
  assign o_s_axi_bresp   = bresp_r;
  assign o_s_axi_rvalid  = rvalid_r;
  assign o_s_axi_rresp   = rresp_r;
  assign o_s_axi_rdata   = rdata_r;

  // ----------------------------------------------------------------------
  // Write channel: address and data in either order
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= '0;
      w_hold_r  <= 1'b0;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= i_s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r  <= i_s_axi_wdata[7:0];
        wstrb0_r <= i_s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        // Status and unmapped words refuse writes
        bresp_r   <= (wr_ok && rd_ok) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && i_s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : g_cfg
      localparam logic [3:0] SLOT = 4'(g);
      localparam logic [7:0] MASK = (SLOT == SLOT_ROLE) ? ROLE_MASK : 8'hFF;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cfg_r[g] <= CFG_RST[g];
        end else if (do_write && wstrb0_r && wr_slot == SLOT) begin
          cfg_r[g] <= wdata_r & MASK;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read channel: one cycle to answer
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= {24'h000000, rd_byte};
    end else if (rvalid_r && i_s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire hold_en = cfg_r[SLOT_HOLD][HOC_EN_BIT];
  wire ext_sel = cfg_r[SLOT_HOLD][HOC_EXT_BIT];
  wire cmp_en  = cfg_r[SLOT_HOLD][HOC_CMP_BIT];
  wire man_en  = hold_en & ext_sel;
  wire auto_en = hold_en & ~ext_sel;

  assign o_digital_lock_detect_en = ~cfg_r[SLOT_LOCK][LDC_DIS_BIT];
  assign o_lock_window_high = ~cfg_r[SLOT_LOCK][LDC_WIN_BIT];
  assign o_lock_count_sel   = cfg_r[SLOT_LOCK][LDC_CNT_LSB+1:LDC_CNT_LSB];
  assign o_lock_pin_ctrl    = cfg_r[SLOT_PIN][PIN_MODE_MSB:0];
  assign o_current_source_lock_detect =
    o_lock_pin_ctrl == PIN_MODE_CUR_SRC;
  assign o_mon_ext_thresh  = cfg_r[SLOT_PIN][PIN_EXT_BIT];
  assign o_ref_auto_switch = cfg_r[SLOT_REF][REF_AUTO_BIT];
  assign o_ref_prefer_second = cfg_r[SLOT_REF][REF_PREF_BIT];
  assign o_ref_buf_en      = cfg_r[SLOT_REF][REF_BUF_LSB+1:REF_BUF_LSB];
  assign o_clk_in_role     = cfg_r[SLOT_ROLE][1:0];
  assign o_pll_on          = o_clk_in_role != ROLE_DIST;

  // ----------------------------------------------------------------------
  // Digital lock detect
  // ----------------------------------------------------------------------
  pho_lock_det u_lock_det (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_enable               (o_digital_lock_detect_en),
    .i_count_sel            (o_lock_count_sel),
    .i_phase_detector_cycle (i_phase_detector_cycle),
    .i_in_window            (i_phase_detector_in_window),
    .i_over_unlock          (i_phase_detector_over_unlock),
    .o_lock        (o_digital_lock_detect)
  );

  // ----------------------------------------------------------------------
  // Pin synchronizers
  // ----------------------------------------------------------------------
  logic align_s1;
  logic align_s2;
  logic align_q;
  logic lock_s1;
  logic lock_s2;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Idle high so reset leaves no pending edge
      align_s1 <= 1'b1;
      align_s2 <= 1'b1;
      align_q  <= 1'b1;
      lock_s1  <= 1'b0;
      lock_s2  <= 1'b0;
    end else begin
      align_s1 <= i_align_n;
      align_s2 <= align_s1;
      align_q  <= align_s2;
      lock_s1  <= i_lock_indicator_cmp;
      lock_s2  <= lock_s1;
    end
  end

  wire lock_eff  = cmp_en ? lock_s2 : 1'b1;
  wire fall_sync = man_en & align_q & ~align_s2;
  // Raw pin lets the pump float before the synchronizer catches up
  wire fall_now  = man_en & align_s2 & ~i_align_n;

  // ----------------------------------------------------------------------
  // Holdover state machine
  // ----------------------------------------------------------------------
  pho_state_t state_r;
  pho_state_t state_nxt;
  logic       armed_r;
  logic       armed_nxt;
  logic       bcnt_nxt;
  logic       bcnt_r;

  wire run       = state_r == ST_RUN;
  wire auto_trig = auto_en & armed_r & ~lock_eff;

  // Reference edges arrive from the selected reference only, so a
  // switchover glitch ends at the new reference's first edge
  always_comb begin
    state_nxt = state_r;
    armed_nxt = armed_r | lock_eff;
    bcnt_nxt  = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (fall_sync) begin
          state_nxt = ST_MAN;
        end else if (auto_trig) begin
          state_nxt = ST_AUTO;
        end
      end
      ST_MAN: begin
        if (!man_en) begin
          state_nxt = ST_RUN;
          armed_nxt = 1'b0;
        end else if (align_s2 && i_phase_detector_ref_edge) begin
          state_nxt = ST_RUN;
          bcnt_nxt  = 1'b1;
          armed_nxt = 1'b0;
        end
      end
      ST_AUTO: begin
        if (!auto_en) begin
          state_nxt = ST_RUN;
          armed_nxt = 1'b0;
        end else if (i_phase_detector_ref_edge) begin
          // No edge, no release: holds while reference is gone
          state_nxt = ST_RUN;
          bcnt_nxt  = 1'b1;
          armed_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_RUN;
      armed_r <= 1'b0;
      bcnt_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      armed_r <= armed_nxt;
      bcnt_r  <= bcnt_nxt;
    end
  end

  assign o_charge_pump_hiz = ~run | fall_now | fall_sync;
  assign o_bcnt_reset      = bcnt_r;

  // ----------------------------------------------------------------------
  // Divider stop and status
  // ----------------------------------------------------------------------
  logic [NUM_DIV-1:0] div_stop_r;
  generate
    for (g = 0; g < NUM_DIV; g++) begin : g_div
      wire ign = cfg_r[SLOT_DIV0 + 4'(g)][DIV_IGN_BIT];
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          div_stop_r[g] <= 1'b0;
        end else begin
          div_stop_r[g] <= ~ign & ~align_s2;
        end
      end
    end
  endgenerate
  assign o_div_stop = div_stop_r;

  // Oscillator monitor watches the clock input once it is selected
  wire osc_low = (o_clk_in_role == ROLE_INT_VCO) ? i_vco_low
                                                 : i_clk_in_low;
  assign status = {i_first_ref_low, i_second_ref_low, osc_low,
                   ~o_digital_lock_detect_en & auto_en, lock_eff,
                   o_digital_lock_detect, armed_r, ~run};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_exit;
    !run ##1 run;
  endsequence

  a_disable_blocks: assert property (
    !hold_en |-> (!fall_now && !fall_sync) ##1 run)
    else $error("holdover active while disabled");
  a_manual_immediate: assert property (
    (man_en && align_s2 && !i_align_n) |-> o_charge_pump_hiz)
    else $error("pump not floated on alignment falling edge");
  a_exit_on_edge: assert property (
    (state_r == ST_MAN && man_en) ##1 run
      |-> $past(i_phase_detector_ref_edge))
    else $error("manual release without reference edge");
  a_bcnt_on_exit: assert property (
    o_bcnt_reset |-> run && $past(state_r) != ST_RUN)
    else $error("B counter reset outside release");
  a_div_stop: assert property (
    (!cfg_r[SLOT_DIV0][DIV_IGN_BIT] && !align_s2) |=> o_div_stop[0])
    else $error("divider not stopped by alignment pin");
  a_auto_entry: assert property (
    (run && auto_en && armed_r && !lock_eff) |=> state_r == ST_AUTO)
    else $error("auto holdover not entered on lost lock");
  a_cmp_off: assert property (
    !cmp_en |-> lock_eff)
    else $error("lock seen low with comparator off");
  a_no_ref_hold: assert property (
    (state_r == ST_AUTO && auto_en && !i_phase_detector_ref_edge)
      |=> state_r == ST_AUTO)
    else $error("auto holdover left without reference");
  a_rearm_gate: assert property (
    s_exit |-> !armed_r ##1 (!auto_trig || $past(lock_eff)))
    else $error("auto holdover re-armed without lock high");
  a_cur_src_code: assert property (
    o_current_source_lock_detect |-> cfg_r[SLOT_PIN][5:0] == 6'h04)
    else $error("current-source mode on wrong code");

endmodule // pho_holdover
`default_nettype wire

// [test/pho_ref_model.sv]
// Partner model: reference detector edges and lock indicator
`timescale 1ns/1ps
`default_nettype none
module pho_ref_model (
  input  wire logic i_clk,
  input  wire logic i_ref_on,
  input  wire logic i_locked,
  output logic      o_ref_edge,
  output logic      o_in_window,
  output logic      o_over_unlock,
  output logic      o_lock_cmp
);
  logic [1:0] ph_r = 2'h0;
  // Edge every fourth cycle; none while the reference is absent
  always_ff @(posedge i_clk) begin
    ph_r       <= ph_r + 2'h1;
    o_ref_edge <= i_ref_on && (ph_r == 2'h3);
  end
  assign o_in_window   = i_locked;
  assign o_over_unlock = !i_locked;
  assign o_lock_cmp    = i_locked;
endmodule // pho_ref_model
`default_nettype wire

// [test/pll_holdover_controller_test.sv]
// Testbench: register bus, manual and automatic holdover
`timescale 1ns/1ps
`default_nettype none
module pll_holdover_controller_test;
  import pho_pkg::*;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic al_n = 1, ref_on = 0, locked = 1;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic awr, wr_, bv, arr, rv, hiz, bcnt, win_hi, csd, mext;
  logic dig_lock, dig_lock_en, aswi, pref2, pll_on;
  logic [1:0]  cnt_sel, role, buf_en;
  logic [5:0]  pin_ctl;
  logic [3:0]  mon = 4'h0;
  logic edg, inw, ovu, cmp;
  logic [3:0]  div_stop;
  int mismatches = 0, check_count = 0;

  pho_ref_model i_pho_ref_model (.i_clk(clk), .i_ref_on(ref_on),
    .i_locked(locked), .o_ref_edge(edg), .o_in_window(inw),
    .o_over_unlock(ovu), .o_lock_cmp(cmp));
  pho_holdover i_pho_holdover (.i_clk(clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .i_align_n(al_n),
    .i_lock_indicator_cmp(cmp), .i_phase_detector_ref_edge(edg),
    .i_phase_detector_cycle(edg), .i_phase_detector_in_window(inw),
    .i_phase_detector_over_unlock(ovu), .i_first_ref_low(mon[3]),
    .i_second_ref_low(mon[2]), .i_vco_low(mon[1]), .i_clk_in_low(mon[0]),
    .o_charge_pump_hiz(hiz), .o_bcnt_reset(bcnt), .o_div_stop(div_stop),
    .o_digital_lock_detect(dig_lock),
    .o_digital_lock_detect_en(dig_lock_en),
    .o_lock_window_high(win_hi), .o_lock_count_sel(cnt_sel),
    .o_lock_pin_ctrl(pin_ctl), .o_current_source_lock_detect(csd),
    .o_mon_ext_thresh(mext), .o_ref_auto_switch(aswi),
    .o_ref_prefer_second(pref2), .o_ref_buf_en(buf_en),
    .o_clk_in_role(role), .o_pll_on(pll_on));

  initial forever #50 clk = ~clk;
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd  <= {24'h0, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask
  // Bounded wait for the release pulse; pump must drop with it
  task automatic wait_rel;
    int n;
    n = 0;
    while (bcnt !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(32'({bcnt, hiz}), 32'h2);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'({hiz, bcnt, div_stop}), 32'h0);
    rd(IDX_HOLD_CTL, 32'h0, RESP_OKAY);
    rd(10'h3FF, 32'h0, RESP_SLVERR);
    wr(IDX_STATUS, 8'hFF);
    chk(32'(bresp), 32'(RESP_SLVERR));
    wr(IDX_CLK_ROLE, 8'hFF);
    rd(IDX_CLK_ROLE, 32'h03, RESP_OKAY);
    wr(IDX_CLK_ROLE, 8'h01);
    mon <= 4'hE;
    chk(32'({role, pll_on}), 32'h2);
    rd(IDX_STATUS, 32'hCA, RESP_OKAY);
    wr(IDX_CLK_ROLE, 8'h00);
    rd(IDX_STATUS, 32'hEA, RESP_OKAY);
    mon <= 4'h0;
    wr(IDX_LOCK_CFG, 8'h78);
    chk(32'({bresp, cnt_sel, dig_lock_en, win_hi}), 32'h0C);
    wr(IDX_LOCK_CFG, 8'h00);
    chk(32'({cnt_sel, dig_lock_en, win_hi}), 32'h3);
    wr(IDX_REF_SEL, 8'h1E);
    chk(32'({aswi, pref2, buf_en}), 32'hF);
    wr(IDX_PIN_MON, 8'h44);
    @(negedge clk);
    chk(32'({pin_ctl, csd, mext}), 32'h13);
    rd(IDX_PIN_MON, 32'h44, RESP_OKAY);
    wr(IDX_DIV0_CTL, 8'h40);
    wr(IDX_HOLD_CTL, 8'h02);
    al_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk(32'({hiz, div_stop}), 32'hE);
    @(posedge clk);
    al_n <= 1'b1;
    repeat (5) @(posedge clk);
    wr(IDX_HOLD_CTL, 8'h03);
    al_n <= 1'b0;
    @(negedge clk);
    chk(32'(hiz), 32'h1);
    repeat (3) @(posedge clk);
    al_n <= 1'b1;
    repeat (12) @(negedge clk);
    chk(32'(hiz), 32'h1);
    @(posedge clk);
    ref_on <= 1'b1;
    wait_rel;
    repeat (40) @(negedge clk);
    chk(32'(dig_lock), 32'h1);
    // Comparator off hides the low indicator from the auto path
    wr(IDX_HOLD_CTL, 8'h01);
    locked <= 1'b0;
    repeat (10) @(negedge clk);
    chk(32'({hiz, dig_lock}), 32'h0);
    @(posedge clk);
    locked <= 1'b1;
    wr(IDX_HOLD_CTL, 8'h09);
    repeat (6) @(posedge clk);
    ref_on <= 1'b0;
    locked <= 1'b0;
    repeat (8) @(negedge clk);
    chk(32'(hiz), 32'h1);
    repeat (12) @(negedge clk);
    chk(32'(hiz), 32'h1);
    rd(IDX_STATUS, 32'h03, RESP_OKAY);
    @(posedge clk);
    ref_on <= 1'b1;
    wait_rel;
    repeat (12) @(negedge clk);
    chk(32'(hiz), 32'h0);
    end_sim;
  end
endmodule // pll_holdover_controller_test
`default_nettype wire
